// [pkg/i2cb_params.svh]
// Timing counts and reset values for the two-wire framing block.
// Assumes a 40 MHz system clock; included by the detector and engine modules.
`ifndef I2CB_PARAMS_SVH
`define I2CB_PARAMS_SVH

// System clock period
`define I2CB_CLK_NS         25
// Half period of the generated serial clock
`define I2CB_HALF_NS        2500
// Extended and default data hold after a falling serial clock edge
`define I2CB_HOLD_LONG_NS   300
`define I2CB_HOLD_SHORT_NS  75
// Least times round up to whole cycles
`define I2CB_HALF_CYC  ((`I2CB_HALF_NS + `I2CB_CLK_NS - 1) / `I2CB_CLK_NS)
`define I2CB_HOLD_LONG_CYC \
    ((`I2CB_HOLD_LONG_NS + `I2CB_CLK_NS - 1) / `I2CB_CLK_NS)
`define I2CB_HOLD_SHORT_CYC \
    ((`I2CB_HOLD_SHORT_NS + `I2CB_CLK_NS - 1) / `I2CB_CLK_NS)
// Bit index of the acknowledge slot; last data bit index
`define I2CB_ACK_BIT        4'h8
`define I2CB_LAST_DATA_BIT  4'h7
// Reset values of the state records
`define I2CB_ENG_RST '{st: ST_IDLE, sda_oe_n: 1'b1, scl_oe_n: 1'b1, \
    default: '0}
`define I2CB_DET_RST '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1, \
    scl_d: 1'b1, sda_d: 1'b1, default: '0}

`endif

// [pkg/i2cb_pkg.sv]
// Types for the two-wire framing and arbitration block.
// Assumes the params header for widths of counters.
package i2cb_pkg;

    // Engine sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_CHK,
        ST_START_HOLD,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_LOST
    } i2cb_st_t;

    // Engine state record
    typedef struct packed {
        i2cb_st_t   st;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic       rd_mode;
        logic       addr_phase;
        logic       sda_oe_n;
        logic       scl_oe_n;
        logic       tx_taken;
        logic [7:0] rx_byte;
        logic       rx_valid;
        logic       ack_ok;
        logic       arb_lost;
        logic       coll;
        logic       start_seen;
        logic       stop_seen;
        logic       busy;
        logic       xfer_busy;
    } i2cb_eng_t;

    // Line condition detector record
    typedef struct packed {
        logic scl_m;
        logic sda_m;
        logic scl_s;
        logic sda_s;
        logic scl_d;
        logic sda_d;
        logic low_seen;
        logic busy;
        logic start_p;
        logic stop_p;
    } i2cb_det_t;

endpackage : i2cb_pkg

// [pkg/i2cb_line_if.sv]
// Carrier of synchronised line levels and bus conditions.
// Assumes detector and engine share one system clock.
`timescale 1ns/10ps
`default_nettype none

interface i2cb_line_if;
    logic scl_s;
    logic sda_s;
    logic start_p;
    logic stop_p;
    logic busy;

    modport det (output scl_s, sda_s, start_p, stop_p, busy);
    modport eng (input scl_s, sda_s, start_p, stop_p, busy);
endinterface : i2cb_line_if

`default_nettype wire

// [core/i2cb_cond_det.sv]
// Synchronises the two bus lines and finds Start and Stop conditions.
// Assumes raw line levels from pins, asynchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "i2cb_params.svh"

module i2cb_cond_det
    import i2cb_pkg::*;
(
    input  wire logic i_clk_sys,  // System clock
    input  wire logic i_rst_n,    // Async reset, active low
    input  wire logic i_enable,   // Port enable
    input  wire logic i_scl,      // Raw clock line level
    input  wire logic i_sda,      // Raw data line level
    i2cb_line_if.det  lines       // Conditions out
);

    i2cb_det_t d_ff;
    i2cb_det_t nxt_d;

    // Two stages, then edge and condition logic
    always_comb
    begin
        nxt_d       = d_ff;
        nxt_d.scl_m = i_scl;
        nxt_d.sda_m = i_sda;
        nxt_d.scl_s = d_ff.scl_m;
        nxt_d.sda_s = d_ff.sda_m;
        nxt_d.scl_d = d_ff.scl_s;
        nxt_d.sda_d = d_ff.sda_s;
        nxt_d.start_p = d_ff.scl_s && d_ff.scl_d
            && d_ff.sda_d && !d_ff.sda_s;
        nxt_d.stop_p  = d_ff.scl_s && d_ff.scl_d && !d_ff.sda_d
            && d_ff.sda_s && d_ff.low_seen;
        if (!d_ff.scl_s)
            nxt_d.low_seen = 1'b1;
        if (nxt_d.start_p)
        begin
            nxt_d.low_seen = 1'b0;
            nxt_d.busy     = 1'b1;
        end
        if (nxt_d.stop_p)
            nxt_d.busy = 1'b0;
        if (!i_enable)
        begin
            nxt_d.busy     = 1'b0;
            nxt_d.low_seen = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            d_ff <= `I2CB_DET_RST;
        else
            d_ff <= nxt_d;
    end

    // Outputs to the engine
    assign lines.scl_s   = d_ff.scl_s;
    assign lines.sda_s   = d_ff.sda_s;
    assign lines.start_p = d_ff.start_p;
    assign lines.stop_p  = d_ff.stop_p;
    assign lines.busy    = d_ff.busy;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // Rising data with clock high and no low period since start
    property p_stop_needs_low;
        (!d_ff.low_seen && d_ff.scl_s) |=> !d_ff.stop_p;
    endproperty
    a_stop_needs_low: assert property (p_stop_needs_low)
        else $error("stop accepted without clock low period");

    property p_start_busy;
        (d_ff.start_p && i_enable) |=> d_ff.busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not mark bus busy");

endmodule : i2cb_cond_det

`default_nettype wire

// [core/i2cb_engine.sv]
// Master byte engine of a two-wire port: framing, conditions, arbitration.
// Assumes pull-ups on both lines and an outside resolver for open drain.
`timescale 1ns/10ps
`default_nettype none
`include "i2cb_params.svh"

module i2cb_engine
    import i2cb_pkg::*;
(
    input  wire logic       i_clk_sys,                // System clock
    input  wire logic       i_rst_n,                  // Async reset, low
    input  wire logic       i_scl,                    // Clock line level
    input  wire logic       i_sda,                    // Data line level
    input  wire logic       i_serial_port_enable,     // Port enable
    input  wire logic       i_data_hold_extend_select, // Long hold
    input  wire logic       i_xfer_req,               // Start a message
    input  wire logic [7:0] i_tx_byte,                // Next byte to send
    input  wire logic       i_tx_valid,               // More bytes to send
    input  wire logic       i_read_more,              // Ack read byte
    output logic            o_scl_out,                // Clock data, zero
    output logic            o_scl_oe_n,               // Clock pull, low
    output logic            o_sda_out,                // Data data, zero
    output logic            o_sda_oe_n,               // Data pull, low
    output logic            o_tx_taken,               // Byte consumed
    output logic [7:0]      o_rx_byte,                // Received byte
    output logic            o_rx_valid,               // Byte received
    output logic            o_ack_status,             // Ack was seen
    output logic            o_bus_busy,               // Bus active
    output logic            o_arb_lost,               // Arbitration lost
    output logic            o_bus_collision,          // Collision seen
    output logic            o_start_seen,             // Start on bus
    output logic            o_stop_seen,              // Stop on bus
    output logic            o_xfer_busy               // Message running
);

    localparam logic [7:0] HALF_CYC  = 8'(`I2CB_HALF_CYC);
    localparam logic [7:0] HOLD_LONG = 8'(`I2CB_HOLD_LONG_CYC);
    localparam logic [7:0] HOLD_SHRT = 8'(`I2CB_HOLD_SHORT_CYC);

    i2cb_line_if lines ();
    i2cb_eng_t   s_ff;
    i2cb_eng_t   nxt_s;
    logic [7:0]  hold_cyc;
    logic        rx_data;
    logic        txing;
    logic        go_on;

    // Synchroniser and condition detector
    i2cb_cond_det u_det (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_enable  (i_serial_port_enable),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .lines     (lines)
    );

    // Hold time and bit role
    assign hold_cyc = i_data_hold_extend_select ? HOLD_LONG : HOLD_SHRT;
    assign rx_data  = s_ff.rd_mode && !s_ff.addr_phase;
    assign txing    = !rx_data && (s_ff.bitn < `I2CB_ACK_BIT);

    // Next-state logic of the engine
    always_comb
    begin
        nxt_s            = s_ff;
        go_on            = 1'b0;
        nxt_s.tx_taken   = 1'b0;
        nxt_s.rx_valid   = 1'b0;
        nxt_s.busy       = lines.busy;
        nxt_s.start_seen = lines.start_p;
        nxt_s.stop_seen  = lines.stop_p;
        if (lines.stop_p)
        begin
            nxt_s.arb_lost = 1'b0;
            nxt_s.coll     = 1'b0;
        end
        case (s_ff.st)
            ST_IDLE:
            begin
                nxt_s.xfer_busy = 1'b0;
                if (i_xfer_req && !lines.busy
                    && lines.scl_s && lines.sda_s)
                begin
                    nxt_s.xfer_busy = 1'b1;
                    nxt_s.st        = ST_START_CHK;
                end
            end
            ST_START_CHK:
            begin
                nxt_s.cnt = 8'h00;
                if (!lines.sda_s)
                begin
                    nxt_s.coll     = 1'b1;
                    nxt_s.arb_lost = 1'b1;
                    nxt_s.st       = ST_LOST;
                end
                else
                begin
                    nxt_s.sda_oe_n = 1'b0;
                    nxt_s.st       = ST_START_HOLD;
                end
            end
            ST_START_HOLD:
            begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == HALF_CYC)
                begin
                    nxt_s.scl_oe_n   = 1'b0;
                    nxt_s.cnt        = 8'h00;
                    nxt_s.bitn       = 4'h0;
                    nxt_s.shreg      = i_tx_byte;
                    nxt_s.rd_mode    = i_tx_byte[0];
                    nxt_s.addr_phase = 1'b1;
                    nxt_s.tx_taken   = 1'b1;
                    nxt_s.st         = ST_BIT_LOW;
                end
            end
            ST_BIT_LOW:
            begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                // Data moves only after the hold, with clock low
                if (s_ff.cnt == hold_cyc)
                begin
                    if (s_ff.bitn == `I2CB_ACK_BIT)
                        nxt_s.sda_oe_n = rx_data ? !i_read_more
                                                 : 1'b1;
                    else
                        nxt_s.sda_oe_n = txing ? s_ff.shreg[7]
                                               : 1'b1;
                end
                if (s_ff.cnt == HALF_CYC)
                begin
                    nxt_s.scl_oe_n = 1'b1;
                    nxt_s.cnt      = 8'h00;
                    nxt_s.st       = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH:
            begin
                if (!lines.scl_s)
                    nxt_s.cnt = 8'h00;
                else
                begin
                    nxt_s.cnt = s_ff.cnt + 8'h01;
                    if (s_ff.cnt == 8'h00)
                    begin
                        // Sample on the first cycle the clock is high
                        if (txing && s_ff.sda_oe_n && !lines.sda_s)
                        begin
                            nxt_s.arb_lost = 1'b1;
                            nxt_s.coll     = 1'b1;
                            nxt_s.sda_oe_n = 1'b1;
                            nxt_s.scl_oe_n = 1'b1;
                            nxt_s.st       = ST_LOST;
                        end
                        else if (s_ff.bitn < `I2CB_ACK_BIT)
                        begin
                            nxt_s.shreg = {s_ff.shreg[6:0], lines.sda_s};
                            if (rx_data
                                && s_ff.bitn == `I2CB_LAST_DATA_BIT)
                            begin
                                nxt_s.rx_byte  = {s_ff.shreg[6:0],
                                                  lines.sda_s};
                                nxt_s.rx_valid = 1'b1;
                            end
                        end
                        else if (!rx_data)
                            nxt_s.ack_ok = !lines.sda_s;
                    end
                    else if (s_ff.cnt == HALF_CYC)
                    begin
                        nxt_s.scl_oe_n = 1'b0;
                        nxt_s.cnt      = 8'h00;
                        if (s_ff.bitn < `I2CB_ACK_BIT)
                        begin
                            nxt_s.bitn = s_ff.bitn + 4'h1;
                            nxt_s.st   = ST_BIT_LOW;
                        end
                        else
                        begin
                            // Unit of nine clocks ends here
                            nxt_s.bitn       = 4'h0;
                            nxt_s.addr_phase = 1'b0;
                            if (s_ff.rd_mode)
                                go_on = s_ff.addr_phase ? s_ff.ack_ok
                                                        : i_read_more;
                            else
                                go_on = s_ff.ack_ok && i_tx_valid;
                            if (go_on && !s_ff.rd_mode)
                            begin
                                nxt_s.shreg    = i_tx_byte;
                                nxt_s.tx_taken = 1'b1;
                            end
                            nxt_s.st = go_on ? ST_BIT_LOW : ST_STOP_LOW;
                        end
                    end
                end
            end
            ST_STOP_LOW:
            begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == hold_cyc)
                    nxt_s.sda_oe_n = 1'b0;
                if (s_ff.cnt == HALF_CYC)
                begin
                    nxt_s.scl_oe_n = 1'b1;
                    nxt_s.cnt      = 8'h00;
                    nxt_s.st       = ST_STOP_HIGH;
                end
            end
            ST_STOP_HIGH:
            begin
                nxt_s.cnt = lines.scl_s ? s_ff.cnt + 8'h01 : 8'h00;
                if (s_ff.cnt == HALF_CYC)
                begin
                    nxt_s.sda_oe_n = 1'b1;
                    nxt_s.cnt      = 8'h00;
                    nxt_s.st       = ST_IDLE;
                end
            end
            ST_LOST:
            begin
                nxt_s.sda_oe_n = 1'b1;
                nxt_s.scl_oe_n = 1'b1;
                if (lines.stop_p)
                    nxt_s.st = ST_IDLE;
            end
            default:
                nxt_s.st = ST_IDLE;
        endcase
        // Disabled port releases the lines and clears the state and the lost and collision flags
        if (!i_serial_port_enable)
        begin
            nxt_s.st        = ST_IDLE;
            nxt_s.sda_oe_n  = 1'b1;
            nxt_s.scl_oe_n  = 1'b1;
            nxt_s.arb_lost  = 1'b0;
            nxt_s.coll      = 1'b0;
            nxt_s.xfer_busy = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_ff <= `I2CB_ENG_RST;
        else
            s_ff <= nxt_s;
    end

    // Pins only pull low or release
    assign o_scl_out       = 1'b0;
    assign o_sda_out       = 1'b0;
    assign o_scl_oe_n      = s_ff.scl_oe_n;
    assign o_sda_oe_n      = s_ff.sda_oe_n;
    assign o_tx_taken      = s_ff.tx_taken;
    assign o_rx_byte       = s_ff.rx_byte;
    assign o_rx_valid      = s_ff.rx_valid;
    assign o_ack_status    = s_ff.ack_ok;
    assign o_bus_busy      = s_ff.busy;
    assign o_arb_lost      = s_ff.arb_lost;
    assign o_bus_collision = s_ff.coll;
    assign o_start_seen    = s_ff.start_seen;
    assign o_stop_seen     = s_ff.stop_seen;
    assign o_xfer_busy     = s_ff.xfer_busy;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_start_idle;
        (s_ff.st == ST_START_CHK && $past(s_ff.st) == ST_IDLE)
            |-> !$past(lines.busy);
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("start begun on a busy bus");

    property p_lost_release;
        $rose(s_ff.arb_lost) |-> o_sda_oe_n && o_scl_oe_n;
    endproperty
    a_lost_release: assert property (p_lost_release)
        else $error("lines still driven after losing");

    property p_lost_wait;
        (s_ff.st == ST_LOST && !lines.stop_p && i_serial_port_enable)
            |=> s_ff.st == ST_LOST && o_scl_oe_n;
    endproperty
    a_lost_wait: assert property (p_lost_wait)
        else $error("lost master left wait before stop");

    property p_start_coll;
        (s_ff.st == ST_START_CHK && !lines.sda_s && i_serial_port_enable)
            |=> o_bus_collision && s_ff.st == ST_LOST;
    endproperty
    a_start_coll: assert property (p_start_coll)
        else $error("collision on start not reported");

    property p_msb_first;
        (s_ff.st == ST_BIT_LOW && txing && s_ff.cnt == hold_cyc + 8'h01)
            |-> o_sda_oe_n == s_ff.shreg[7];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("data bit is not the top bit");

    property p_hold;
        (s_ff.st == ST_BIT_LOW && s_ff.cnt > 8'h00
            && s_ff.cnt <= hold_cyc) |-> $stable(o_sda_oe_n) && !o_scl_oe_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("data moved inside hold time");

    property p_stretch;
        (s_ff.st == ST_BIT_HIGH && !lines.scl_s && i_serial_port_enable)
            |=> s_ff.st == ST_BIT_HIGH && s_ff.cnt == 8'h00;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock advanced while held low");

    property p_ack_release;
        (s_ff.st == ST_BIT_HIGH && s_ff.bitn == `I2CB_ACK_BIT && !rx_data)
            |-> o_sda_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("sender holds data in acknowledge slot");

    property p_disable;
        !i_serial_port_enable |=> o_sda_oe_n && o_scl_oe_n
            && !o_arb_lost && !o_bus_collision;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disabled port still drives or flags");

    property p_stop_clear;
        (lines.stop_p && s_ff.st == ST_LOST)
            |=> !o_arb_lost && !o_bus_collision;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("flags survive a stop");

    property p_nine;
        s_ff.bitn <= `I2CB_ACK_BIT;
    endproperty
    a_nine: assert property (p_nine)
        else $error("unit longer than nine clocks");

    c_lost: cover property ($rose(s_ff.arb_lost));
    c_read: cover property (s_ff.rx_valid);
    c_two_bytes: cover property (s_ff.tx_taken && !s_ff.addr_phase);
    c_stop: cover property (s_ff.st == ST_STOP_HIGH ##1 s_ff.st == ST_IDLE);

endmodule : i2cb_engine

`default_nettype wire

// [testbench/i2cb_slave_model.sv]
// Slave on the two wires: acks bytes, sends read data after a read address.
// Assumes lines resolved with pull-ups by the bench.
`timescale 1ns/10ps
`default_nettype none
module i2cb_slave_model (
    input  wire logic       i_scl,      // Clock line
    input  wire logic       i_sda,      // Data line
    input  wire logic       i_ack_en,   // Ack written bytes
    input  wire logic [7:0] i_rd_byte,  // Byte to send on read
    output logic            o_sda_oe_n  // Low pulls data line
);
    int         bitc = 0;
    logic       first = 1'b1;
    logic       rd = 1'b0;
    logic       nack = 1'b1;
    logic [7:0] sh = 8'h00;
    initial o_sda_oe_n = 1'b1;
    // Start or Stop restarts the frame
    always @(i_sda) if (i_scl)
    begin
        bitc = -1;
        first = 1'b1;
        rd = 1'b0;
    end
    // Sample on rise
    always @(posedge i_scl)
    begin
        sh = {sh[6:0], i_sda};
        nack = i_sda;
    end
    // Drive well after the fall, only while clock is low
    always @(negedge i_scl)
    begin
        bitc = bitc + 1;
        if (bitc == 8 && first)
            rd = sh[0];
        if (bitc == 9)
        begin
            bitc = 0;
            if (!first && nack)
                rd = 1'b0;
            first = 1'b0;
        end
        if (bitc == 8)
            o_sda_oe_n <= #400 !(i_ack_en && (first || !rd));
        else
            o_sda_oe_n <= #400 !(rd && !i_rd_byte[7 - bitc]);
    end
endmodule : i2cb_slave_model
`default_nettype wire

// [testbench/i2cb_bus_tb.sv]
// Bench for the two-wire engine: writes, read, nack, lost arbitration.
// Assumes open-drain lines resolved here with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module i2cb_bus_tb;
    logic clk = 0, rst_n = 0, en = 0, hold = 0, req = 0, txv = 0, rdm = 0;
    logic ack_en = 1, comp_oe_n = 1, sl_oe_n, scl_oe_n, sda_oe_n, scl_o, sda_o;
    logic tx_taken, ack_st, busy, arb, coll, xbusy, rxv, sta, sto;
    logic [7:0] tx_byte = 0, rd_byte = 0, rx_byte, a, d, q_bus[$];
    logic [7:0] msh;
    int nb = 0, n_fail = 0, n_checks = 0, k;
    int n_rxv = 0, n_sta = 0, n_sto = 0;
    realtime t_fall, dt_min;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & sl_oe_n & comp_oe_n;
    always #12.5 clk = ~clk;
    i2cb_engine i2cb_engine_i (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_scl(scl), .i_sda(sda), .i_serial_port_enable(en),
        .i_data_hold_extend_select(hold), .i_xfer_req(req),
        .i_tx_byte(tx_byte), .i_tx_valid(txv), .i_read_more(rdm),
        .o_scl_out(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda_out(sda_o),
        .o_sda_oe_n(sda_oe_n), .o_tx_taken(tx_taken), .o_rx_byte(rx_byte),
        .o_rx_valid(rxv), .o_ack_status(ack_st), .o_bus_busy(busy),
        .o_arb_lost(arb), .o_bus_collision(coll), .o_start_seen(sta),
        .o_stop_seen(sto), .o_xfer_busy(xbusy));
    i2cb_slave_model i2cb_slave_model_i (.i_scl(scl), .i_sda(sda),
        .i_ack_en(ack_en), .i_rd_byte(rd_byte), .o_sda_oe_n(sl_oe_n));
    // Reference monitor: bytes off the wire, shortest data hold
    always @(sda) if (scl) nb = 0;
    always @(negedge scl) t_fall = $realtime;
    always @(sda) if (!scl && $realtime - t_fall < dt_min)
        dt_min = $realtime - t_fall;
    always @(posedge scl)
    begin
        if (nb < 8) msh = {msh[6:0], sda};
        nb = nb + 1;
        if (nb == 9) q_bus.push_back(msh);
        if (nb == 9) nb = 0;
    end
    // Pulse counts of starts, stops and received bytes
    always @(negedge clk)
    begin
        n_rxv = n_rxv + rxv;
        n_sta = n_sta + sta;
        n_sto = n_sto + sto;
    end
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One whole message; second written byte only when more is set
    task automatic run(input logic [7:0] ab, db, input logic more);
        q_bus.delete();
        dt_min = 1e9;
        req = 1;
        tx_byte = ab;
        txv = more;
        for (k = 0; k < 9000 && tx_taken !== 1'b1; k++) @(negedge clk);
        chk("taken", 1, tx_taken);
        req = 0;
        tx_byte = db;
        @(negedge clk);
        for (k = 0; more && k < 9000 && tx_taken !== 1'b1; k++) @(negedge clk);
        if (more) chk("next taken", 1, tx_taken);
        txv = 0;
        for (k = 0; k < 30000 && (xbusy || busy); k++) @(negedge clk);
        chk("done", 0, {xbusy, busy});
    endtask : run
    task close_out;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    initial
    begin
        #1500000;
        n_fail++;
        close_out();
    end
    initial
    begin
        void'($urandom(85));
        repeat (8) @(negedge clk);
        rst_n = 1;
        en = 1;
        repeat (3) @(negedge clk);
        chk("pin data", 0, {scl_o, sda_o});
        for (int h = 0; h < 2; h++)
        begin
            hold = h[0];
            a = 8'($urandom) & 8'hfe;
            d = 8'($urandom);
            run(a, d, 1);
            chk("bus addr", a, q_bus[0]);
            chk("bus data", d, q_bus[1]);
            chk("ack", 1, ack_st);
            chk("hold", 1, dt_min >= (h ? 300 : 75));
            chk("idle", 0, busy);
        end
        rd_byte = 8'($urandom);
        run(8'($urandom) | 8'h01, 0, 0);
        chk("read", rd_byte, rx_byte);
        chk("bus rd", rd_byte, q_bus[1]);
        ack_en = 0;
        run(8'($urandom) & 8'hfe, 0, 0);
        chk("nack", 0, ack_st);
        // Rival pulls data low under our first address bit
        req = 1;
        tx_byte = 8'hff;
        for (k = 0; k < 9000 && tx_taken !== 1'b1; k++) @(negedge clk);
        req = 0;
        repeat (20) @(negedge clk);
        comp_oe_n = 0;
        for (k = 0; k < 9000 && arb !== 1'b1; k++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk("lost", 3, {arb, coll});
        chk("release", 3, {sda_oe_n, scl_oe_n});
        chk("active", 1, busy);
        comp_oe_n = 1;
        for (k = 0; k < 300 && arb !== 1'b0; k++) @(negedge clk);
        chk("cleared", 0, {arb, coll, busy});
        // Data already low when our Start is due; no Stop without clock low
        comp_oe_n = 0;
        @(negedge clk);
        req = 1;
        repeat (3) @(negedge clk);
        req = 0;
        comp_oe_n = 1;
        chk("start coll", 3, {arb, coll});
        repeat (10) @(negedge clk);
        chk("no stop", 3, {arb, busy});
        en = 0;
        repeat (2) @(negedge clk);
        chk("disabled", 0, {arb, coll, busy});
        chk("off pins", 3, {sda_oe_n, scl_oe_n});
        en = 1;
        chk("starts", 6, 8'(n_sta));
        chk("stops", 5, 8'(n_sto));
        chk("rx pulses", 1, 8'(n_rxv));
        close_out();
    end
endmodule : i2cb_bus_tb
`default_nettype wire
